//--- vint_consts.vh
// Constants for the interrupt-flag privilege checker.
// Assumes inclusion by bare name from design files in the same folder.
`ifndef VINT_CONSTS_VH
`define VINT_CONSTS_VH

`define PRIV_USER 2'h3
`define PRIV_KERNEL 2'h0
`define VEC_MASKABLE_LO 8'h20
`define VEC_MASKABLE_HI 8'hff
`define FLAG_IF 9
`define FLAG_IOLVL_LO 12
`define FLAG_IOLVL_HI 13
`define FLAG_VM 17
`define FLAG_VIRQ 19
`define FLAG_VPEND 20
`define IO_MAX_BYTES 4
`define FLAGS_RESET 32'h00000002
`define IOMAP_BITS 65536
`define PORT_W 16
`define FAULT_NONE 3'h0
`define FAULT_GP 3'h1
`define FAULT_PAGE 3'h2
`define OP_NONE 4'h0
`define OP_IRQ_CLR 4'h1
`define OP_IRQ_SET 4'h2
`define OP_FLAG_PUSH 4'h3
`define OP_FLAG_POP 4'h4
`define OP_IRQ_RET 4'h5
`define OP_SOFTINT 4'h6
`define OP_IO 4'h7
`define OP_FARCALL 4'h8
`define OP_TASKSW 4'h9
`define OP_MEM 4'ha

`endif

//--- io_perm_map.v
// Per-task I/O permission bitmap with a multi-bit lookup.
// Assumes software loads the map from the task state image before use.
`timescale 1ns/100ps
`include "vint_consts.vh"

module io_perm_map (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Map load port
    input wire load_en,
    input wire [`PORT_W-1:0] load_port,
    input wire load_bit,
    // Lookup
    input wire [`PORT_W-1:0] port,
    input wire [2:0] size,
    output reg denied
);
    reg map [0:`IOMAP_BITS-1];
    integer i;

    // Each of the first four bytes the access touches must be clear; a set bit denies.
    always @* begin
        denied = 1'b0;
        for (i = 0; i < `IO_MAX_BYTES; i = i + 1) begin
            if (i < size) begin
                denied = denied | map[port + i[`PORT_W-1:0]];
            end
        end
    end

    always @(posedge clock) begin
        if (load_en) begin
            map[load_port] <= load_bit;
        end
    end
endmodule

//--- virtual_interrupt_priv_check.v
// Privilege checker for interrupt-flag, flag-stack and port instructions.
// Assumes one decoded instruction per cycle from the core, same clock.
//
// Behaviour
// - User clear/set toggle virtual flag, no fault
// - Maskable irq with virtual flag set faults
// - User set-enable with pending interrupt faults
// - Only vectors 32..255 are virtualised
// - Fallback: fault when privilege exceeds io level
// - Fallback: clear/set act on real enable
// - Flag push/pop/return stay legacy behaviour
// - Virtual flags ignored unless privilege is three
// - Legacy virtual mode via switch, return, flag pop or software flag write
// - Privilege calls leave flags untouched
// - Legacy virtual sensitive ops fault below three
// - Legacy virtual mode reads privilege three
// - Legacy virtual port ops ignore io level
// - Legacy virtual ports checked against bitmap
// - Not-present page access raises exception
// - Hardware never writes virtual pending flag
`timescale 1ns/100ps
`include "vint_consts.vh"

module virtual_interrupt_priv_check (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Configuration
    input wire prot_virt_irq_enable,
    input wire virtual_mode_extension,
    input wire [1:0] segment_priv_level,
    // Instruction issue
    input wire instr_valid,
    input wire [3:0] instr_op,
    input wire [31:0] instr_flags_in,
    input wire [15:0] io_port,
    input wire [2:0] io_size,
    input wire page_present,
    // Interrupt request
    input wire irq_valid,
    input wire [7:0] irq_vector,
    input wire irq_is_nmi,
    // Software flag write (handler writes the saved image back)
    input wire flags_write,
    input wire [31:0] flags_write_data,
    // Bitmap load
    input wire iomap_load,
    input wire [15:0] iomap_port,
    input wire iomap_bit,
    // Results
    output reg [31:0] flags_register,
    output reg [31:0] saved_flags,
    output reg [1:0] current_priv_level,
    output reg [2:0] fault_kind,
    output reg fault_valid,
    output reg irq_deliver,
    output reg [7:0] irq_deliver_vector,
    output reg done
);
    wire denied;
    wire virq_flag = flags_register[`FLAG_VIRQ];
    wire virq_pend = flags_register[`FLAG_VPEND];
    wire vm = flags_register[`FLAG_VM];
    wire [1:0] io_level = flags_register[`FLAG_IOLVL_HI:`FLAG_IOLVL_LO];
    // Legacy virtual mode always runs at user privilege.
    wire [1:0] priv_now = vm ? `PRIV_USER : segment_priv_level;
    // Virtual flags are only consulted at user privilege.
    wire virt_mode = prot_virt_irq_enable & ~vm & (priv_now == `PRIV_USER)
        & (io_level != `PRIV_USER);
    wire maskable = ~irq_is_nmi & (irq_vector >= `VEC_MASKABLE_LO)
        & (irq_vector <= `VEC_MASKABLE_HI);
    reg [31:0] next_flags;
    reg [2:0] next_fault;
    reg next_deliver;

    io_perm_map perm (
        .clock(clock),
        .rst(rst),
        .load_en(iomap_load),
        .load_port(iomap_port),
        .load_bit(iomap_bit),
        .port(io_port),
        .size(io_size),
        .denied(denied)
    );

    // ==========================================================
    // Instruction check
    // ==========================================================
    // A fault leaves the flags as they were unless flags_write lands in the same cycle outside legacy virtual mode;
    // in legacy virtual mode the VM bit clears and saved_flags keeps the state before the trapping instruction.
    always @* begin
        next_flags = flags_register;
        next_fault = `FAULT_NONE;
        next_deliver = 1'b0;
        if (instr_valid) begin
            case (instr_op)
                `OP_IRQ_CLR, `OP_IRQ_SET: begin
                    if (vm) begin
                        if (io_level != `PRIV_USER) begin
                            next_fault = `FAULT_GP;
                        end else begin
                            next_flags[`FLAG_IF] = (instr_op == `OP_IRQ_SET);
                        end
                    end else if (virt_mode) begin
                        if (instr_op == `OP_IRQ_CLR) begin
                            next_flags[`FLAG_VIRQ] = 1'b1;
                        end else if (virq_pend) begin
                            next_fault = `FAULT_GP;
                        end else begin
                            next_flags[`FLAG_VIRQ] = 1'b0;
                        end
                    end else if (priv_now > io_level) begin
                        next_fault = `FAULT_GP;
                    end else begin
                        next_flags[`FLAG_IF] = (instr_op == `OP_IRQ_SET);
                    end
                end
                `OP_FLAG_PUSH, `OP_FLAG_POP, `OP_IRQ_RET, `OP_SOFTINT: begin
                    if (vm && io_level != `PRIV_USER) begin
                        next_fault = `FAULT_GP;
                    end else if (instr_op == `OP_FLAG_POP || instr_op == `OP_IRQ_RET) begin
                        // Legacy restore; may enter legacy virtual mode.
                        next_flags = instr_flags_in;
                    end
                end
                `OP_TASKSW: begin
                    next_flags = instr_flags_in;
                end
                `OP_IO: begin
                    if (vm) begin
                        if (denied) begin
                            next_fault = `FAULT_GP;
                        end
                    end else if (priv_now > io_level) begin
                        next_fault = `FAULT_GP;
                    end
                end
                `OP_MEM: begin
                    if (!page_present) begin
                        next_fault = `FAULT_PAGE;
                    end
                end
                `OP_FARCALL: begin
                    next_flags = flags_register;
                end
                default: begin
                    next_flags = flags_register;
                end
            endcase
        end else if (irq_valid) begin
            if (maskable && virt_mode && virq_flag) begin
                next_fault = `FAULT_GP;
            end else if (!maskable || flags_register[`FLAG_IF]) begin
                next_deliver = 1'b1;
            end
        end
        if (flags_write) begin
            // Only software updates the pending flag.
            next_flags = flags_write_data;
        end
    end

    // ==========================================================
    // State
    // ==========================================================
    always @(posedge clock) begin
        if (rst) begin
            flags_register <= `FLAGS_RESET;
            saved_flags <= `FLAGS_RESET;
            current_priv_level <= `PRIV_KERNEL;
            fault_kind <= `FAULT_NONE;
            fault_valid <= 1'b0;
            irq_deliver <= 1'b0;
            irq_deliver_vector <= `VEC_MASKABLE_LO;
            done <= 1'b0;
        end else begin
            fault_kind <= next_fault;
            fault_valid <= (next_fault != `FAULT_NONE);
            irq_deliver <= next_deliver;
            irq_deliver_vector <= irq_vector;
            done <= instr_valid | irq_valid;
            current_priv_level <= priv_now;
            if (next_fault != `FAULT_NONE && vm) begin
                // A fault in legacy virtual mode saves the flags image before leaving it.
                saved_flags <= flags_register;
                flags_register <= flags_register & ~(32'h1 << `FLAG_VM);
            end else begin
                flags_register <= next_flags;
            end
        end
    end
endmodule

//--- vint_props.sv
// Concurrent checks on the ports of the interrupt-flag privilege checker.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module vint_props (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Requests
    input wire prot_virt_irq_enable,
    input wire instr_valid,
    input wire [3:0] instr_op,
    input wire page_present,
    input wire irq_valid,
    input wire [7:0] irq_vector,
    input wire irq_is_nmi,
    input wire flags_write,
    // Results
    input wire [31:0] flags_register,
    input wire [1:0] current_priv_level,
    input wire [2:0] fault_kind,
    input wire fault_valid,
    input wire irq_deliver
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ==========
    // Decode
    wire vm = flags_register[17];
    wire iop3 = flags_register[13:12] == 2'h3;
    wire pv = prot_virt_irq_enable && !vm && current_priv_level == 2'h3 && !iop3;
    wire io_string_in_instr = instr_valid && !flags_write;
    wire clr_op = io_string_in_instr && instr_op == 4'h1;
    wire set_op = io_string_in_instr && instr_op == 4'h2;
    wire gp = fault_valid && fault_kind == 3'h1;
    wire irq = irq_valid && !instr_valid;
    // ==========
    // Properties
    property p_vcli;
        clr_op && pv |=> flags_register[19] && flags_register[9] == $past(flags_register[9])
            && !fault_valid;
    endproperty
    a_vcli: assert property (p_vcli) else $error("virtual clear wrong");
    property p_vsti;
        set_op && pv && flags_register[20] |=> gp && $stable(flags_register);
    endproperty
    a_vsti: assert property (p_vsti) else $error("pending set no fault");
    property p_virq;
        irq && pv && flags_register[19] && !irq_is_nmi && irq_vector >= 8'h20 |=> gp && !irq_deliver;
    endproperty
    a_virq: assert property (p_virq) else $error("masked irq no fault");
    property p_nmi;
        irq && irq_is_nmi |=> irq_deliver && !fault_valid;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi not delivered");
    property p_fb;
        (clr_op || set_op) && !vm && !pv && current_priv_level > flags_register[13:12] |=> gp;
    endproperty
    a_fb: assert property (p_fb) else $error("fallback no fault");
    property p_if;
        (clr_op || set_op) && iop3 |=> flags_register[9] == $past(set_op) && !fault_valid;
    endproperty
    a_if: assert property (p_if) else $error("enable flag wrong");
    property p_vm;
        io_string_in_instr && vm && !iop3 && instr_op inside {[4'h1:4'h6]} |=> gp;
    endproperty
    a_vm: assert property (p_vm) else $error("sensitive op no fault");
    property p_page;
        io_string_in_instr && instr_op == 4'ha && !page_present |=> fault_valid && fault_kind == 3'h2;
    endproperty
    a_page: assert property (p_page) else $error("page fault missing");
    cover property (clr_op && pv);
    cover property (irq && irq_is_nmi);
    cover property (io_string_in_instr && vm && instr_op == 4'h7);
endmodule

bind virtual_interrupt_priv_check vint_props u_props (.clock, .rst, .prot_virt_irq_enable,
    .instr_valid, .instr_op, .page_present, .irq_valid, .irq_vector, .irq_is_nmi,
    .flags_write, .flags_register, .current_priv_level, .fault_kind, .fault_valid, .irq_deliver);

//--- tb_virtual_interrupt_priv_check.sv
// Self-checking bench for the interrupt-flag privilege checker.
// Assumes the design and its checker are compiled alongside.
`timescale 1ns/100ps
module tb_virtual_interrupt_priv_check;
    logic clock = 0;
    logic rst = 1;
    logic prot_virt_irq_enable = 0, virtual_mode_extension = 0, instr_valid = 0;
    logic page_present = 1, irq_valid = 0, irq_is_nmi = 0, flags_write = 0;
    logic iomap_load = 0, iomap_bit = 0;
    logic [1:0] segment_priv_level = 2'h3;
    logic [3:0] instr_op = 4'h0;
    logic [31:0] instr_flags_in = 32'h0, flags_write_data = 32'h0;
    logic [15:0] io_port = 16'h0, iomap_port = 16'h0;
    logic [2:0] io_size = 3'h1;
    logic [7:0] irq_vector = 8'h0;
    wire [31:0] flags_register, saved_flags;
    wire [1:0] current_priv_level;
    wire [2:0] fault_kind;
    wire fault_valid, irq_deliver, done;
    wire [7:0] irq_deliver_vector;
    int errors = 0;
    int check_count = 0;
    always #10 clock = ~clock;
    virtual_interrupt_priv_check u_dut (.clock, .rst, .prot_virt_irq_enable,
        .virtual_mode_extension, .segment_priv_level, .instr_valid, .instr_op,
        .instr_flags_in, .io_port, .io_size, .page_present, .irq_valid, .irq_vector,
        .irq_is_nmi, .flags_write, .flags_write_data, .iomap_load, .iomap_port, .iomap_bit,
        .flags_register, .saved_flags, .current_priv_level, .fault_kind, .fault_valid,
        .irq_deliver, .irq_deliver_vector, .done);
    // ==========
    // Drivers and compare
    task chk(input string n, input [31:0] e, input [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task wf(input [31:0] d);
        @(posedge clock);
        flags_write <= 1;
        flags_write_data <= d;
        @(posedge clock);
        flags_write <= 0;
    endtask
    task map(input [15:0] p, input b);
        @(posedge clock);
        iomap_load <= 1;
        iomap_port <= p;
        iomap_bit <= b;
        @(posedge clock);
        iomap_load <= 0;
    endtask
    task op(input [3:0] o, input [31:0] ef, input [2:0] ek);
        @(posedge clock);
        instr_valid <= 1;
        instr_op <= o;
        @(posedge clock);
        instr_valid <= 0;
        #1;
        chk("done", 1, done);
        chk("fault_valid", ek != 0, fault_valid);
        chk("fault_kind", ek, fault_kind);
        chk("flags", ef, flags_register);
    endtask
    task irq(input [7:0] v, input n, input [2:0] ek, input dl);
        @(posedge clock);
        irq_valid <= 1;
        irq_vector <= v;
        irq_is_nmi <= n;
        @(posedge clock);
        irq_valid <= 0;
        #1;
        chk("fault_kind", ek, fault_kind);
        chk("deliver", dl, irq_deliver);
        chk("vector", v, irq_deliver_vector);
    endtask
    // ==========
    // Scenarios
    task t_pvi;
        prot_virt_irq_enable <= 1;
        wf(32'h2);
        op(4'h1, 32'h80002, 0);
        op(4'h2, 32'h2, 0);
        op(4'h1, 32'h80002, 0);
        irq(8'h20, 0, 1, 0);
        irq(8'h02, 1, 0, 1);
        wf(32'h180002);
        op(4'h2, 32'h180002, 1);
        wf(32'h202);
        irq(8'h40, 0, 0, 1);
        segment_priv_level <= 2'h0;
        wf(32'h202);
        op(4'h1, 32'h2, 0);
        segment_priv_level <= 2'h3;
        $display("virtual flag test done");
    endtask
    task t_fall;
        prot_virt_irq_enable <= 0;
        wf(32'h2);
        op(4'h1, 32'h2, 1);
        wf(32'h3202);
        op(4'h1, 32'h3002, 0);
        op(4'h2, 32'h3202, 0);
        $display("fallback test done");
    endtask
    task t_vm;
        segment_priv_level <= 2'h0;
        wf(32'h20002);
        @(posedge clock);
        #1;
        chk("cpl", 3, current_priv_level);
        op(4'h3, 32'h2, 1);
        chk("saved", 32'h20002, saved_flags);
        instr_flags_in <= 32'h23002;
        op(4'h5, 32'h23002, 0);
        op(4'h2, 32'h23202, 0);
        op(4'h8, 32'h23202, 0);
        map(16'h60, 0);
        map(16'h61, 1);
        io_port <= 16'h60;
        wf(32'h20002);
        op(4'h7, 32'h20002, 0);
        io_size <= 3'h2;
        op(4'h7, 32'h2, 1);
        page_present <= 0;
        op(4'ha, 32'h2, 2);
        $display("legacy virtual test done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        finish_test;
    end
    initial begin
        repeat (12) @(posedge clock);
        rst <= 0;
        @(posedge clock);
        #1;
        chk("reset flags", 32'h2, flags_register);
        t_pvi;
        t_fall;
        t_vm;
        finish_test;
    end
endmodule
